/* File: rtl/pfsw_pkg.sv */
// Package: register map, field layout and timing for the flash self-write path
//
// Contract
// RQ1: Table address is page byte above effective address
// RQ2: Low-word table access reaches bits 15..0
// RQ3: High-word table access reaches bits 23..16
// RQ4: Erase one page or program double word
// RQ5: Processor stalled until operation finishes
// RQ6: Start bit 15 launches, hardware clears it
// RQ7: Program only at every other word address; the device programs at any address it is given
// RQ8: Key 0x55 then 0xAA required before start
// RQ9: Two no-operations follow setting start bit
// RQ10: Erase page before reprogramming its words; the device programs without checking for an erase
// RQ11: Operation address is high byte over low word
// RQ12: Start bit set only, hardware clears it
// RQ13: Write-enable bit 14 gates all operations
// RQ14: Code 0001 programs; reserved codes do nothing
// RQ15: Key register write-only, reads zero
// RQ16: Address registers read/write, high upper byte zero
// RQ17: Error flag bit 13 set on bad sequence
// RQ18: Code 0011 erases one page
// RQ19: Select and enable frozen while busy
package pfsw_pkg;

  // ----------------------------------------------------------------------
  // Device register selectors on the core-side port
  // ----------------------------------------------------------------------
  localparam logic [1:0] REG_CONTROL   = 2'h0;
  localparam logic [1:0] REG_ADDR_HIGH = 2'h1;
  localparam logic [1:0] REG_ADDR_LOW  = 2'h2;
  localparam logic [1:0] REG_KEY       = 2'h3;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int START_BIT     = 15;
  localparam int WRITE_EN_BIT  = 14;
  localparam int ERR_BIT       = 13;
  localparam int IDLE_SBY_BIT  = 12;
  localparam int OP_LSB        = 0;
  localparam int OP_W          = 4;
  localparam logic [3:0]  OP_PROGRAM_DW = 4'h1;
  localparam logic [3:0]  OP_ERASE_PAGE = 4'h3;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ----------------------------------------------------------------------
  // Self-timed operation lengths, in aclk cycles
  // ----------------------------------------------------------------------
  localparam int          CLK_MHZ       = 40;
  localparam int          ERASE_TIME_US = 20;
  localparam int          PROG_TIME_US  = 5;
  localparam logic [15:0] ERASE_CYCLES  = 16'(ERASE_TIME_US * CLK_MHZ);
  localparam logic [15:0] PROG_CYCLES   = 16'(PROG_TIME_US * CLK_MHZ);

  // ----------------------------------------------------------------------
  // AXI4-Lite map of the controller (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] AX_CMD     = 8'h00; // [15:0] control image write
  localparam logic [7:0] AX_ADDR    = 8'h04; // [23:0] operation address
  localparam logic [7:0] AX_STATUS  = 8'h08; // [0] busy [1] error
  localparam logic [7:0] AX_IRQ_ST  = 8'h0C; // [0] done [1] error, W1C
  localparam logic [7:0] AX_IRQ_MSK = 8'h10;
  localparam logic [7:0] AX_TBL     = 8'h14; // [23:16] page [15:0] offset
  localparam logic [7:0] AX_TBL_DAT = 8'h18; // [23:0] table data
  localparam logic [7:0] AX_TBL_GO  = 8'h1C; // [0] write [1] high word

  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_RUN  = 2'b01
  } pfsw_dev_state_t;

endpackage : pfsw_pkg

/* File: rtl/pfsw_if.sv */
// Interface: register and table port between core-side controller and device
`timescale 1ns/100ps
interface pfsw_if;
  logic        reg_we;
  logic [1:0]  reg_sel;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        tbl_req;
  logic        tbl_write;
  logic        tbl_high;
  logic [7:0]  tbl_page;
  logic [15:0] tbl_eff_addr;
  logic [15:0] tbl_wdata;
  logic [15:0] tbl_rdata;
  logic [23:0] tbl_addr;
  logic        stall;

  modport device (
    input  reg_we, reg_sel, reg_wdata, tbl_req, tbl_write, tbl_high,
           tbl_page, tbl_eff_addr, tbl_wdata,
    output reg_rdata, tbl_rdata, tbl_addr, stall
  );
  modport host (
    output reg_we, reg_sel, reg_wdata, tbl_req, tbl_write, tbl_high,
           tbl_page, tbl_eff_addr, tbl_wdata,
    input  reg_rdata, tbl_rdata, tbl_addr, stall
  );
endinterface : pfsw_if

/* File: rtl/pfsw_device.sv */
// Flash self-write controller: control, key, address and table latch
`timescale 1ns/100ps
module pfsw_device (
  // Clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // Core-side port
  pfsw_if.device      bus,
  // Flash array side
  output logic        flash_erase,
  output logic        flash_program,
  output logic [23:0] flash_addr,
  output logic [47:0] flash_data,
  output logic        flash_idle_standby
);

  typedef struct packed {
    pfsw_pkg::pfsw_dev_state_t st;
    logic        start;
    logic        wr_en;
    logic        err;
    logic        idle_sby;
    logic [3:0]  op;
    logic [7:0]  adr_hi;
    logic [15:0] adr_lo;
    logic        key_armed;
    logic        key_half;
    logic [15:0] cnt;
    logic [47:0] latch;
    logic [15:0] tbl_rd;
    logic [23:0] tbl_ad;
    logic        ers;
    logic        prg;
  } pfsw_dev_t;

  pfsw_dev_t s_reg, s_next;
  logic [23:0] taddr;
  logic [15:0] ctl_img;

  assign taddr = {bus.tbl_page, bus.tbl_eff_addr}; // RQ1
  assign ctl_img = {s_reg.start, s_reg.wr_en, s_reg.err, s_reg.idle_sby,
                    8'h00, s_reg.op};

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ers = 1'b0;
    s_next.prg = 1'b0;
    if (bus.tbl_req) begin
      s_next.tbl_ad = taddr;
      if (bus.tbl_write && !bus.tbl_high) begin
        s_next.latch[{taddr[1], 4'h0} +: 16] = bus.tbl_wdata; // RQ2
      end else if (bus.tbl_write) begin
        s_next.latch[6'd32 + {taddr[1], 3'h0} +: 8] =
          bus.tbl_wdata[7:0]; // RQ3
      end else if (!bus.tbl_high) begin
        s_next.tbl_rd = s_reg.latch[{taddr[1], 4'h0} +: 16]; // RQ2
      end else begin
        s_next.tbl_rd = {8'h00,
          s_reg.latch[6'd32 + {taddr[1], 3'h0} +: 8]}; // RQ3
      end
    end
    if (bus.reg_we) begin
      s_next.key_armed = 1'b0;
      s_next.key_half = 1'b0;
      unique case (bus.reg_sel)
        pfsw_pkg::REG_CONTROL: begin
          if (s_reg.st == pfsw_pkg::DEV_IDLE) begin
            s_next.wr_en = bus.reg_wdata[pfsw_pkg::WRITE_EN_BIT]; // RQ19
            s_next.op = bus.reg_wdata[pfsw_pkg::OP_LSB +: pfsw_pkg::OP_W];
            s_next.err = bus.reg_wdata[pfsw_pkg::ERR_BIT];
          end
          s_next.idle_sby = bus.reg_wdata[pfsw_pkg::IDLE_SBY_BIT];
          if (bus.reg_wdata[pfsw_pkg::START_BIT] &&
              s_reg.st == pfsw_pkg::DEV_IDLE) begin // RQ12
            if (s_reg.key_armed && s_reg.wr_en &&
                bus.reg_wdata[pfsw_pkg::WRITE_EN_BIT]) begin // RQ8 RQ13
              s_next.start = 1'b1; // RQ6
              s_next.st = pfsw_pkg::DEV_RUN;
              s_next.err = 1'b0;
              if (s_next.op == pfsw_pkg::OP_ERASE_PAGE) begin // RQ18
                s_next.ers = 1'b1; // RQ4
                s_next.cnt = pfsw_pkg::ERASE_CYCLES;
              end else if (s_next.op == pfsw_pkg::OP_PROGRAM_DW) begin
                s_next.prg = 1'b1; // RQ4
                s_next.cnt = pfsw_pkg::PROG_CYCLES;
              end else begin
                s_next.cnt = 16'h0001; // RQ14
              end
            end else begin
              s_next.err = 1'b1; // RQ17
            end
          end
        end
        pfsw_pkg::REG_ADDR_HIGH: s_next.adr_hi = bus.reg_wdata[7:0]; // RQ16
        pfsw_pkg::REG_ADDR_LOW:  s_next.adr_lo = bus.reg_wdata; // RQ16
        pfsw_pkg::REG_KEY: begin
          // Armed only by 0xAA right after 0x55; any other write disarms
          s_next.key_half = bus.reg_wdata[7:0] == pfsw_pkg::KEY_FIRST;
          s_next.key_armed = s_reg.key_half &&
            bus.reg_wdata[7:0] == pfsw_pkg::KEY_SECOND; // RQ8
        end
      endcase
    end
    if (s_reg.st == pfsw_pkg::DEV_RUN) begin
      if (s_reg.cnt <= 16'h0001) begin
        s_next.st = pfsw_pkg::DEV_IDLE;
        s_next.start = 1'b0; // RQ6
        s_next.cnt = 16'h0000;
      end else begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.st <= pfsw_pkg::DEV_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Read path: key reads zero, high address upper byte zero
  always_comb begin
    unique case (bus.reg_sel)
      pfsw_pkg::REG_CONTROL:   bus.reg_rdata = ctl_img;
      pfsw_pkg::REG_ADDR_HIGH: bus.reg_rdata = {8'h00, s_reg.adr_hi}; // RQ16
      pfsw_pkg::REG_ADDR_LOW:  bus.reg_rdata = s_reg.adr_lo;
      pfsw_pkg::REG_KEY:       bus.reg_rdata = 16'h0000; // RQ15
    endcase
  end

  assign bus.stall = (s_reg.st == pfsw_pkg::DEV_RUN); // RQ5
  assign bus.tbl_rdata = s_reg.tbl_rd;
  assign bus.tbl_addr = s_reg.tbl_ad;
  assign flash_erase = s_reg.ers;
  assign flash_program = s_reg.prg;
  assign flash_addr = {s_reg.adr_hi, s_reg.adr_lo}; // RQ11
  assign flash_data = s_reg.latch;
  assign flash_idle_standby = s_reg.idle_sby;

endmodule : pfsw_device

/* File: rtl/pfsw_host.sv */
// Core-side controller: AXI4-Lite registers driving the device port
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module pfsw_host (
  // Clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // AXI4-Lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Interrupt
  output logic             irq,
  // Device port
  pfsw_if.host             dev
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_AH   = 3'b001,
    H_AL   = 3'b010,
    H_K1   = 3'b011,
    H_K2   = 3'b100,
    H_GO   = 3'b101,
    H_NOP  = 3'b110,
    H_WAIT = 3'b111
  } pfsw_host_state_t;

  typedef struct packed {
    pfsw_host_state_t st;
    logic        aw_ok;
    logic [7:0]  aw_a;
    logic        w_ok;
    logic [31:0] w_d;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [15:0] cmd;
    logic [23:0] addr;
    logic [23:0] tbl;
    logic [23:0] tdat;
    logic [1:0]  irq_st;
    logic [1:0]  irq_msk;
    logic [1:0]  nops;
  } pfsw_host_s_t;

  pfsw_host_s_t s_reg, s_next;
  logic do_wr;
  logic [1:0] ev;

  assign do_wr = s_reg.aw_ok && s_reg.w_ok && !s_reg.bv;

  // --------------------------------------------------------------------
  // Bus slave and command sequencer
  // --------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    ev = 2'b00;
    dev.reg_we = 1'b0;
    dev.reg_sel = pfsw_pkg::REG_CONTROL;
    dev.reg_wdata = 16'h0000;
    dev.tbl_req = 1'b0;
    dev.tbl_write = 1'b0;
    dev.tbl_high = 1'b0;
    if (awvalid && !s_reg.aw_ok) begin
      s_next.aw_ok = 1'b1;
      s_next.aw_a = awaddr;
    end
    if (wvalid && !s_reg.w_ok) begin
      s_next.w_ok = 1'b1;
      s_next.w_d = wdata;
    end
    if (s_reg.bv && bready) s_next.bv = 1'b0;
    if (s_reg.rv && rready) s_next.rv = 1'b0;
    if (do_wr) begin
      s_next.aw_ok = 1'b0;
      s_next.w_ok = 1'b0;
      s_next.bv = 1'b1;
      s_next.br = pfsw_pkg::RESP_OKAY;
      unique case (s_reg.aw_a)
        pfsw_pkg::AX_CMD: begin
          if (s_reg.st == H_IDLE) begin
            s_next.cmd = s_reg.w_d[15:0];
            s_next.st = H_AH;
          end else s_next.br = pfsw_pkg::RESP_SLVERR;
        end
        pfsw_pkg::AX_ADDR:    s_next.addr = s_reg.w_d[23:0];
        pfsw_pkg::AX_IRQ_ST:  s_next.irq_st = s_reg.irq_st & ~s_reg.w_d[1:0];
        pfsw_pkg::AX_IRQ_MSK: s_next.irq_msk = s_reg.w_d[1:0];
        pfsw_pkg::AX_TBL:     s_next.tbl = s_reg.w_d[23:0];
        pfsw_pkg::AX_TBL_DAT: s_next.tdat = s_reg.w_d[23:0];
        pfsw_pkg::AX_TBL_GO: begin
          dev.tbl_req = 1'b1;
          dev.tbl_write = s_reg.w_d[0];
          dev.tbl_high = s_reg.w_d[1];
        end
        default: s_next.br = pfsw_pkg::RESP_SLVERR;
      endcase
    end
    if (arvalid && !s_reg.rv) begin
      s_next.rv = 1'b1;
      s_next.rr = pfsw_pkg::RESP_OKAY;
      unique case (araddr)
        pfsw_pkg::AX_CMD:     s_next.rd = {16'h0000, s_reg.cmd};
        pfsw_pkg::AX_ADDR:    s_next.rd = {8'h00, s_reg.addr};
        pfsw_pkg::AX_STATUS:  s_next.rd = {30'h0,
          dev.reg_rdata[pfsw_pkg::ERR_BIT] && s_reg.st == H_IDLE,
          s_reg.st != H_IDLE};
        pfsw_pkg::AX_IRQ_ST:  s_next.rd = {30'h0, s_reg.irq_st};
        pfsw_pkg::AX_IRQ_MSK: s_next.rd = {30'h0, s_reg.irq_msk};
        pfsw_pkg::AX_TBL:     s_next.rd = {8'h00, s_reg.tbl};
        pfsw_pkg::AX_TBL_DAT: s_next.rd = {16'h0000, dev.tbl_rdata};
        default: begin
          s_next.rd = 32'h0000_0000;
          s_next.rr = pfsw_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Address, key pair, start, then two idle cycles before polling
    unique case (s_reg.st)
      H_IDLE: ;
      H_AH: begin
        dev.reg_we = 1'b1;
        dev.reg_sel = pfsw_pkg::REG_ADDR_HIGH;
        dev.reg_wdata = {8'h00, s_reg.addr[23:16]}; // RQ11
        s_next.st = H_AL;
      end
      H_AL: begin
        dev.reg_we = 1'b1;
        dev.reg_sel = pfsw_pkg::REG_ADDR_LOW;
        dev.reg_wdata = s_reg.addr[15:0];
        s_next.st = H_K1;
      end
      H_K1: begin
        dev.reg_we = 1'b1;
        dev.reg_sel = pfsw_pkg::REG_CONTROL;
        dev.reg_wdata = s_reg.cmd & 16'h7FFF;
        s_next.st = H_K2;
      end
      H_K2: begin
        dev.reg_we = 1'b1;
        dev.reg_sel = pfsw_pkg::REG_KEY;
        dev.reg_wdata = {8'h00, s_reg.nops[0] ? pfsw_pkg::KEY_SECOND
                                              : pfsw_pkg::KEY_FIRST}; // RQ8
        s_next.nops = s_reg.nops + 2'd1;
        if (s_reg.nops[0]) begin
          s_next.st = H_GO;
          s_next.nops = 2'd0;
        end
      end
      H_GO: begin
        dev.reg_we = 1'b1;
        dev.reg_sel = pfsw_pkg::REG_CONTROL;
        dev.reg_wdata = s_reg.cmd;
        s_next.st = s_reg.cmd[pfsw_pkg::START_BIT] ? H_NOP : H_IDLE;
      end
      H_NOP: begin
        s_next.nops = s_reg.nops + 2'd1; // RQ9
        if (s_reg.nops == 2'd1) begin
          s_next.st = H_WAIT;
          s_next.nops = 2'd0;
        end
      end
      H_WAIT: begin
        if (!dev.stall) begin // RQ5
          s_next.st = H_IDLE;
          ev[pfsw_pkg::IRQ_DONE] = 1'b1;
          ev[pfsw_pkg::IRQ_ERR] = dev.reg_rdata[pfsw_pkg::ERR_BIT]; // RQ17
        end
      end
    endcase
    s_next.irq_st = s_next.irq_st | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.st <= H_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dev.tbl_page  = s_reg.tbl[23:16]; // RQ1
  assign dev.tbl_eff_addr = s_reg.tbl[15:0];
  assign dev.tbl_wdata = dev.tbl_high ? {8'h00, s_reg.tdat[23:16]}
                                      : s_reg.tdat[15:0];
  assign awready = !s_reg.aw_ok;
  assign wready  = !s_reg.w_ok;
  assign bvalid  = s_reg.bv;
  assign bresp   = s_reg.br;
  assign arready = !s_reg.rv;
  assign rvalid  = s_reg.rv;
  assign rdata   = s_reg.rd;
  assign rresp   = s_reg.rr;
  assign irq     = |(s_reg.irq_st & s_reg.irq_msk);

endmodule : pfsw_host

/* File: test/pfsw_props.sv */
// Checker: properties of the core-to-device register and table port
`timescale 1ns/100ps
module pfsw_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Port signals
  input wire logic        reg_we,
  input wire logic [1:0]  reg_sel,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        tbl_req,
  input wire logic [7:0]  tbl_page,
  input wire logic [15:0] tbl_eff_addr,
  input wire logic [23:0] tbl_addr,
  input wire logic        stall
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Helper decode and run-length counter
  // ----------------------------------------------------------------
  logic        ctl_w;
  logic        key_55;
  logic        key_aa;
  logic [3:0]  run_op;
  logic [15:0] run_len;
  logic [15:0] exp_len;
  assign ctl_w  = reg_we && reg_sel == pfsw_pkg::REG_CONTROL;
  assign key_55 = reg_we && reg_sel == pfsw_pkg::REG_KEY
                  && reg_wdata[7:0] == pfsw_pkg::KEY_FIRST;
  assign key_aa = reg_we && reg_sel == pfsw_pkg::REG_KEY
                  && reg_wdata[7:0] == pfsw_pkg::KEY_SECOND;
  assign exp_len = run_op == pfsw_pkg::OP_PROGRAM_DW ? pfsw_pkg::PROG_CYCLES
                 : run_op == pfsw_pkg::OP_ERASE_PAGE ? pfsw_pkg::ERASE_CYCLES
                 : 16'h0001;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_op  <= 4'h0;
      run_len <= 16'h0000;
    end else begin
      if (ctl_w && !stall) run_op <= reg_wdata[3:0];
      run_len <= stall ? run_len + 16'h0001 : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_NEED_KEY: assert property ($rose(stall) |-> $past(ctl_w)
    && $past(reg_wdata[15]) && $past(key_aa, 2) && $past(key_55, 3))
    else $error("run began without the unlock pair");
  AST_WRITE_EN_GATE: assert property ($rose(stall) |->
    $past(reg_wdata[14]) && $past(reg_wdata[14], 4))
    else $error("run began with write enable low");
  AST_GO: assert property (ctl_w && reg_wdata[15:14] == 2'b11
    && $past(key_aa) && $past(key_55, 2) && $past(ctl_w, 3)
    && $past(reg_wdata[14], 3) && !stall |=> stall)
    else $error("valid start did not stall");
  AST_START_HOLDS: assert property (stall
    && reg_sel == pfsw_pkg::REG_CONTROL |-> reg_rdata[15])
    else $error("start bit low while running");
  AST_START_CLEARS: assert property ($fell(stall) ##1
    reg_sel == pfsw_pkg::REG_CONTROL |-> !reg_rdata[15])
    else $error("start bit left set after run");
  // One cycle of slack either way on the self-timed length
  AST_RUN_LEN: assert property ($fell(stall) |->
    run_len + 16'h0001 >= exp_len && run_len <= exp_len + 16'h0001)
    else $error("run length wrong for the operation");
  AST_STALL_BOUND: assert property ($rose(stall) |-> ##[1:1000] !stall)
    else $error("stall never released");
  AST_KEY_RD: assert property (reg_sel == pfsw_pkg::REG_KEY |->
    reg_rdata == 16'h0000)
    else $error("key register read not zero");
  AST_ADRH_RD: assert property (reg_sel == pfsw_pkg::REG_ADDR_HIGH |->
    reg_rdata[15:8] == 8'h00)
    else $error("address high upper byte not zero");
  AST_TBL_ADDR: assert property (tbl_req |=>
    tbl_addr == {$past(tbl_page), $past(tbl_eff_addr)})
    else $error("table address not page over ea");

  cover property ($fell(stall) && run_op == pfsw_pkg::OP_ERASE_PAGE);
  cover property ($fell(stall) && run_op == pfsw_pkg::OP_PROGRAM_DW);
  cover property (ctl_w && reg_wdata[15] && !stall ##1 !stall);
  cover property (tbl_req);
endmodule : pfsw_props

/* File: test/program_flash_self_write_control_tb.sv */
// Testbench: controller and device joined, driven over AXI4-Lite
`timescale 1ns/100ps
module program_flash_self_write_control_tb;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        aclk, aresetn, irq, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        flash_erase, flash_program, flash_idle_standby;
  logic [7:0]  awaddr, araddr, page;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp, imask;
  logic [23:0] flash_addr, pulse_addr, addr;
  logic [47:0] flash_data;
  logic [15:0] rnd, eff_addr;
  int          bad_count, samples_checked, n_prog, n_erase, i;

  pfsw_if bus_if ();
  pfsw_host pfsw_host_inst (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .irq(irq), .dev(bus_if));
  pfsw_device pfsw_device_inst (.aclk(aclk), .aresetn(aresetn),
    .bus(bus_if), .flash_erase(flash_erase), .flash_program(flash_program),
    .flash_addr(flash_addr), .flash_data(flash_data),
    .flash_idle_standby(flash_idle_standby));
  pfsw_props pfsw_props_inst (.aclk(aclk), .aresetn(aresetn),
    .reg_we(bus_if.reg_we), .reg_sel(bus_if.reg_sel),
    .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata),
    .tbl_req(bus_if.tbl_req), .tbl_page(bus_if.tbl_page),
    .tbl_eff_addr(bus_if.tbl_eff_addr), .tbl_addr(bus_if.tbl_addr),
    .stall(bus_if.stall));

  always #12.5 aclk = ~aclk;

  // Pulses counted mid-cycle, away from the launching edge
  always @(negedge aclk) begin
    if (flash_program === 1'b1) begin
      n_prog++;
      pulse_addr = flash_addr;
    end
    if (flash_erase === 1'b1) begin
      n_erase++;
      pulse_addr = flash_addr;
    end
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic hang();
    check(32'h0, 32'h1);
    end_sim();
  endtask : hang

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) hang();
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) hang();
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic clr_irq();
    axi_wr(pfsw_pkg::AX_IRQ_ST, 32'h00000003);
    axi_rd(pfsw_pkg::AX_IRQ_ST, rd);
    check(rd, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask : clr_irq

  task automatic run_op(input logic [15:0] cmd, input int ep, input int ee,
                        input logic er, input logic poke);
    int p0, e0, n;
    p0 = n_prog;
    e0 = n_erase;
    axi_wr(pfsw_pkg::AX_CMD, {16'h0000, cmd});
    check({30'h0, rsp}, {30'h0, pfsw_pkg::RESP_OKAY});
    if (poke) begin
      axi_wr(pfsw_pkg::AX_CMD, 32'h0000C003);
      check({30'h0, rsp}, {30'h0, pfsw_pkg::RESP_SLVERR});
    end
    rd = 32'h0;
    for (n = 0; n < 400 && rd[1:0] == 2'b00; n++)
      axi_rd(pfsw_pkg::AX_IRQ_ST, rd);
    if (rd[1:0] == 2'b00) hang();
    check({31'h0, rd[1]}, {31'h0, er});
    check({31'h0, irq}, {31'h0, imask != 2'b00});
    axi_rd(pfsw_pkg::AX_STATUS, rd);
    check(rd, {30'h0, er, 1'b0});
    check(32'(n_prog - p0), 32'(ep));
    check(32'(n_erase - e0), 32'(ee));
    $display("test op %h done", cmd);
  endtask : run_op

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    rnd = 16'hDB1A;
    {bad_count, samples_checked, n_prog, n_erase} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(pfsw_pkg::AX_STATUS, rd);
    check(rd, 32'h0);
    check({31'h0, irq}, 32'h0);
    axi_rd(8'h20, rd);
    check({rd[29:0], rsp}, {30'h0, pfsw_pkg::RESP_SLVERR});
    axi_wr(8'h24, 32'hFFFFFFFF);
    check({30'h0, rsp}, {30'h0, pfsw_pkg::RESP_SLVERR});
    $display("test reset and unmapped done");
    imask = 2'h3;
    axi_wr(pfsw_pkg::AX_IRQ_MSK, {30'h0, imask});
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      page = rnd[7:0];
      rnd = lfsr(rnd);
      eff_addr = {rnd[15:2], i[0], 1'b0};
      rnd = lfsr(rnd);
      axi_wr(pfsw_pkg::AX_TBL, {8'h0, page, eff_addr});
      axi_wr(pfsw_pkg::AX_TBL_DAT, {8'h0, rnd[7:0], rnd});
      axi_wr(pfsw_pkg::AX_TBL_GO, {30'h0, i[1], 1'b1});
      axi_rd(pfsw_pkg::AX_STATUS, rd);
      check({8'h0, bus_if.tbl_addr}, {8'h0, page, eff_addr});
      if (i[1]) check({24'h0, flash_data[32 + 8 * i[0] +: 8]},
                      {24'h0, rnd[7:0]});
      else check({16'h0, flash_data[16 * i[0] +: 16]}, {16'h0, rnd});
      axi_wr(pfsw_pkg::AX_TBL_GO, {30'h0, i[1], 1'b0});
      axi_rd(pfsw_pkg::AX_TBL_DAT, rd);
      check(rd, {16'h0, i[1] ? {8'h0, rnd[7:0]} : rnd});
    end
    $display("test table done");
    // Erase the page first, then program a word inside it
    rnd = lfsr(rnd);
    addr = {rnd[7:0], rnd[15:2], 2'b10};
    for (i = 0; i < 2; i++) begin
      axi_wr(pfsw_pkg::AX_ADDR, {8'h0, addr});
      axi_rd(pfsw_pkg::AX_ADDR, rd);
      check(rd, {8'h0, addr});
      if (i == 0) run_op(16'hC003, 0, 1, 1'b0, 1'b1);
      else run_op(16'hC001, 1, 0, 1'b0, 1'b0);
      check({8'h0, pulse_addr}, {8'h0, addr});
      clr_irq();
    end
    for (i = 0; i < 16; i++) begin
      if (i != 1 && i != 3) begin
        run_op({3'b110, i[1], 8'h00, i[3:0]}, 0, 0, 1'b0, 1'b0);
        check({31'h0, flash_idle_standby}, {31'h0, i[1]});
        clr_irq();
      end
    end
    imask = 2'h0;
    axi_wr(pfsw_pkg::AX_IRQ_MSK, 32'h0);
    run_op(16'h8001, 0, 0, 1'b1, 1'b0);
    imask = 2'h3;
    axi_wr(pfsw_pkg::AX_IRQ_MSK, {30'h0, imask});
    axi_rd(pfsw_pkg::AX_STATUS, rd);
    check({31'h0, irq}, 32'h1);
    clr_irq();
    run_op(16'hC001, 1, 0, 1'b0, 1'b0);
    clr_irq();
    end_sim();
  end
endmodule : program_flash_self_write_control_tb
